// >>> rtl/lba_arbiter_panel.sv
`timescale 1ns/1ps
`include "lba_defines.svh"
// Summary of operation
// - Simultaneous requests resolve by fixed order: LAN, serial, SCSI, VME, CPU.
// - Local data bus is 32-bit synchronous with bursts and snooping.
// - Reset press resets onboard devices; drives backplane reset only as system controller.
// - Software control bit can disable the reset pushbutton entirely.
// - Enabled abort press raises interrupt at software-chosen level; otherwise nothing.
// - Red fail lamp lit while board fail is active, three clock cycles behind the pin.
// - Yellow status lamp follows only a software bit.
// - Green run lamp lit while transfer in progress line is low.
// - System controller lamp lit while board is the system controller.
// - LAN lamp lit while the LAN controller owns the local bus.
// - SCSI lamp lit while the SCSI processor owns the local bus.
// - VME lamp lit while interface drives address strobe or owns the local bus.
module lba_arbiter_panel
    import lba_pkg::*;
#(
    parameter int NUM_MASTERS = 5,
    parameter int DATA_WIDTH = 32,
    parameter int FILTER_CYC = `LBA_DEBOUNCE_CYC,
    parameter int RESET_PULSE_CYC = `LBA_RESET_PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    // local bus arbitration, bit 0 LAN .. bit 4 CPU
    input wire logic [NUM_MASTERS-1:0] bus_request_i,
    input wire logic bus_busy_n_i,
    output logic [NUM_MASTERS-1:0] bus_grant_o,
    // local bus and system status lines from pins
    input wire logic transfer_in_progress_n_i,
    input wire logic board_fail_i,
    input wire logic sys_controller_i,
    input wire logic vme_strobe_driven_i,
    // front panel pushbuttons, high while pressed
    input wire logic reset_button_i,
    input wire logic abort_button_i,
    // reset and interrupt outputs
    output logic board_reset_o,
    output logic sysreset_o,
    output logic abort_irq_o,
    output logic [2:0] abort_irq_level_o,
    // front panel lamps
    output logic fail_led_o,
    output logic stat_led_o,
    output logic run_led_o,
    output logic sys_controller_led_o,
    output logic lan_led_o,
    output logic scsi_led_o,
    output logic vme_led_o
);
    localparam int PW = $clog2(RESET_PULSE_CYC + 1);
    localparam int NSYNC = 7;

    // bus width is fixed by the local bus definition
    if (DATA_WIDTH != 32) begin : g_width_check
        $error("local data bus must be 32 bits wide");
    end

    typedef struct packed {
        lba_arb_state_type arb;
        lba_master_type owner;
        logic [NUM_MASTERS-1:0] grant;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [PW-1:0] rst_count;
        logic board_reset;
        logic sysreset;
        logic abort_irq;
        logic [2:0] abort_level;
        logic fail_led;
        logic stat_led;
        logic run_led;
        logic sys_controller_led_led;
        logic lan_led;
        logic scsi_led;
        logic vme_led;
    } lba_top_state_type;

    lba_top_state_type state_q, state_d;
    logic [NSYNC-1:0] pins_sync;
    logic tip_n_s;
    logic fail_s;
    logic sys_controller_led_s;
    logic as_drv_s;
    logic reset_btn_s;
    logic abort_btn_s;
    logic busy_n_s;
    logic reset_press;
    logic abort_press;

    // highest-priority requester, lowest index wins
    function automatic lba_master_type pick_master(input logic [NUM_MASTERS-1:0] req);
        lba_master_type m;
        m = LBA_M_NONE;
        for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
            if (req[i]) begin
                m = lba_master_type'(i[2:0]);
            end
        end
        return m;
    endfunction

    // one-hot grant for a master code
    function automatic logic [NUM_MASTERS-1:0] grant_of(input lba_master_type m);
        logic [NUM_MASTERS-1:0] g;
        g = '0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (m == lba_master_type'(i[2:0])) begin
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    // strobe aimed at one register index
    function automatic logic reg_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] idx);
        return strobe && (addr == idx);
    endfunction

    // control word as stored: unused bits always read back as zero
    function automatic logic [31:0] ctrl_of_write(input logic [31:0] w);
        logic [31:0] c;
        c = 32'h0000_0000;
        c[`LBA_CTRL_RESET_EN] = w[`LBA_CTRL_RESET_EN];
        c[`LBA_CTRL_ABORT_EN] = w[`LBA_CTRL_ABORT_EN];
        c[`LBA_CTRL_STAT_LED] = w[`LBA_CTRL_STAT_LED];
        c[`LBA_CTRL_ABORT_LVL_HI:`LBA_CTRL_ABORT_LVL_LO] = w[`LBA_CTRL_ABORT_LVL_HI:`LBA_CTRL_ABORT_LVL_LO];
        return c;
    endfunction

    // status word: arbiter state, synchronised pin levels and the two event outputs
    function automatic logic [31:0] status_word(
        input lba_arb_state_type arb,
        input logic tip_active,
        input logic fail,
        input logic sys_controller_led,
        input logic rst_pulse,
        input logic irq
    );
        logic [31:0] s;
        s = 32'h0000_0000;
        s[2:1] = arb;
        s[3] = tip_active;
        s[4] = fail;
        s[5] = sys_controller_led;
        s[6] = rst_pulse;
        s[7] = irq;
        return s;
    endfunction

    // grant word: one-hot grant in the low bits ORed with the owner code above
    function automatic logic [31:0] grant_word(
        input lba_master_type owner,
        input logic [NUM_MASTERS-1:0] g
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[6:4] = owner;
        w[NUM_MASTERS-1:0] = w[NUM_MASTERS-1:0] | g;
        return w;
    endfunction

    // reset pulse counter: a gated press reloads it, otherwise it runs down to zero
    function automatic logic [PW-1:0] pulse_next(input logic [PW-1:0] cnt, input logic start);
        logic [PW-1:0] n;
        n = cnt;
        if (cnt != '0) begin
            n = cnt - PW'(1);
        end
        if (start) begin
            n = PW'(RESET_PULSE_CYC);
        end
        return n;
    endfunction

    // abort flag: a status read or a disable clears it; a gated press in the same cycle beats the read
    function automatic logic abort_next(input logic cur, input logic read_clr, input logic press, input logic en);
        logic n;
        n = cur;
        if (read_clr) begin
            n = 1'b0;
        end
        if (press && en) begin
            n = 1'b1;
        end
        if (!en) begin
            n = 1'b0;
        end
        return n;
    endfunction

    // all pin inputs except the bus requests pass two flip-flops
    lba_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({
            bus_busy_n_i,
            abort_button_i,
            reset_button_i,
            vme_strobe_driven_i,
            sys_controller_i,
            board_fail_i,
            transfer_in_progress_n_i
        }),
        .sync_o(pins_sync)
    );

    assign tip_n_s = pins_sync[0];
    assign fail_s = pins_sync[1];
    assign sys_controller_led_s = pins_sync[2];
    assign as_drv_s = pins_sync[3];
    assign reset_btn_s = pins_sync[4];
    assign abort_btn_s = pins_sync[5];
    assign busy_n_s = pins_sync[6];

    // reset pushbutton filter
    lba_button #(
        .FILTER_CYC(FILTER_CYC)
    ) u_reset_btn (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pressed_i(reset_btn_s),
        .press_o(reset_press)
    );

    // abort pushbutton filter
    lba_button #(
        .FILTER_CYC(FILTER_CYC)
    ) u_abort_btn (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pressed_i(abort_btn_s),
        .press_o(abort_press)
    );

    // next-state logic
    always_comb begin
        state_d = state_q;
        state_d.rdata = '0;

        // register writes
        if (reg_hit(reg_write_i, reg_addr_i, `LBA_REG_CTRL)) begin
            state_d.ctrl = ctrl_of_write(reg_wdata_i);
        end

        // register reads, data valid the cycle after the strobe
        if (reg_read_i) begin
            unique case (reg_addr_i)
                `LBA_REG_CTRL: state_d.rdata = state_q.ctrl;
                `LBA_REG_STATUS: state_d.rdata = status_word(state_q.arb, ~tip_n_s, fail_s, sys_controller_led_s,
                                                             state_q.board_reset, state_q.abort_irq);
                `LBA_REG_GRANT: state_d.rdata = grant_word(state_q.owner, state_q.grant);
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end

        // arbiter: grant stands until the owner releases; the next grant waits for the bus to go idle
        unique case (state_q.arb)
            LBA_ST_IDLE: begin
                if (busy_n_s && pick_master(bus_request_i) != LBA_M_NONE) begin
                    state_d.owner = pick_master(bus_request_i);
                    state_d.grant = grant_of(pick_master(bus_request_i));
                    state_d.arb = LBA_ST_OWNED;
                end
            end
            LBA_ST_OWNED: begin
                // owner keeps request up for its whole cycle or burst
                if (!(|(bus_request_i & state_q.grant))) begin
                    state_d.grant = '0;
                    state_d.arb = LBA_ST_RELEASE;
                end
            end
            LBA_ST_RELEASE: begin
                // wait for the last cycle on the 32-bit bus to finish
                if (busy_n_s && tip_n_s) begin
                    state_d.owner = LBA_M_NONE;
                    state_d.arb = LBA_ST_IDLE;
                end
            end
            default: begin
                // unused state code: drop any grant and start over
                state_d.grant = '0;
                state_d.owner = LBA_M_NONE;
                state_d.arb = LBA_ST_IDLE;
            end
        endcase

        // reset pushbutton
        state_d.rst_count = pulse_next(state_q.rst_count, reset_press && state_q.ctrl[`LBA_CTRL_RESET_EN]);
        state_d.board_reset = state_d.rst_count != '0;
        state_d.sysreset = state_d.board_reset && sys_controller_led_s;

        // abort pushbutton: sticky, cleared by a status read; a new press wins
        state_d.abort_irq = abort_next(state_q.abort_irq, reg_hit(reg_read_i, reg_addr_i, `LBA_REG_STATUS),
                                       abort_press, state_q.ctrl[`LBA_CTRL_ABORT_EN]);
        state_d.abort_level = state_q.ctrl[`LBA_CTRL_ABORT_LVL_HI:`LBA_CTRL_ABORT_LVL_LO];

        // lamps
        state_d.fail_led = fail_s;
        state_d.stat_led = state_q.ctrl[`LBA_CTRL_STAT_LED];
        state_d.run_led = !tip_n_s;
        state_d.sys_controller_led_led = sys_controller_led_s;
        state_d.lan_led = state_q.grant[LBA_M_LAN];
        state_d.scsi_led = state_q.grant[LBA_M_SCSI];
        state_d.vme_led = as_drv_s || state_q.grant[LBA_M_VME];
    end

    // registered state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.arb <= LBA_ST_IDLE;
            state_q.owner <= LBA_M_NONE;
            state_q.ctrl <= `LBA_CTRL_RESET_VAL;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o = state_q.rdata;
    assign bus_grant_o = state_q.grant;
    assign board_reset_o = state_q.board_reset;
    assign sysreset_o = state_q.sysreset;
    assign abort_irq_o = state_q.abort_irq;
    assign abort_irq_level_o = state_q.abort_level;
    assign fail_led_o = state_q.fail_led;
    assign stat_led_o = state_q.stat_led;
    assign run_led_o = state_q.run_led;
    assign sys_controller_led_o = state_q.sys_controller_led_led;
    assign lan_led_o = state_q.lan_led;
    assign scsi_led_o = state_q.scsi_led;
    assign vme_led_o = state_q.vme_led;
endmodule // lba_arbiter_panel

// >>> rtl/lba_defines.svh
`ifndef LBA_DEFINES_SVH
`define LBA_DEFINES_SVH

// register indices on the plain register port
`define LBA_REG_CTRL 4'h0
`define LBA_REG_STATUS 4'h1
`define LBA_REG_GRANT 4'h2

// control register field positions
`define LBA_CTRL_RESET_EN 0
`define LBA_CTRL_ABORT_EN 1
`define LBA_CTRL_STAT_LED 2
`define LBA_CTRL_ABORT_LVL_LO 4
`define LBA_CTRL_ABORT_LVL_HI 6

// control register reset value: both switches disabled, level 0
`define LBA_CTRL_RESET_VAL 32'h0000_0000

// pushbutton filter time and clock rate
`define LBA_DEBOUNCE_US 1
`define LBA_CLK_MHZ 100
`define LBA_DEBOUNCE_CYC (`LBA_DEBOUNCE_US * `LBA_CLK_MHZ)

// length of the reset pulse issued on a reset press, in cycles
`define LBA_RESET_PULSE_CYC 16

`endif

// >>> rtl/lba_pkg.sv
package lba_pkg;
    // local bus masters in grant order, index 0 highest priority
    typedef enum logic [2:0] {
        LBA_M_LAN,
        LBA_M_SERIAL,
        LBA_M_SCSI,
        LBA_M_VME,
        LBA_M_CPU,
        LBA_M_NONE
    } lba_master_type;

    // arbiter sequencing
    typedef enum logic [1:0] {
        LBA_ST_IDLE,
        LBA_ST_OWNED,
        LBA_ST_RELEASE
    } lba_arb_state_type;
endpackage

// >>> rtl/lba_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module lba_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } lba_sync_state_type;

    lba_sync_state_type state_q, state_d;

    // first stage feeds only the second
    always_comb begin
        state_d = state_q;
        state_d.meta = async_i;
        state_d.stable = state_q.meta;
    end

    // registered state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stable;
endmodule // lba_sync

// >>> rtl/lba_button.sv
`timescale 1ns/1ps
`include "lba_defines.svh"
// pushbutton filter: emits one pulse per settled press
module lba_button #(
    parameter int FILTER_CYC = `LBA_DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // synchronised button level, high while pressed
    input wire logic pressed_i,
    // one-cycle pulse on the settled press edge
    output logic press_o
);
    localparam int CW = $clog2(FILTER_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic level;
        logic press;
    } lba_button_state_type;

    lba_button_state_type state_q, state_d;

    // count how long the input has differed from the settled level
    always_comb begin
        state_d = state_q;
        state_d.press = 1'b0;
        if (pressed_i == state_q.level) begin
            state_d.count = '0;
        end else if (state_q.count == CW'(FILTER_CYC - 1)) begin
            state_d.count = '0;
            state_d.level = pressed_i;
            state_d.press = pressed_i;
        end else begin
            state_d.count = state_q.count + CW'(1);
        end
    end

    // registered state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign press_o = state_q.press;
endmodule // lba_button

// >>> sim/lba_master_model.sv
`timescale 1ns/1ps
// local bus masters: each waits for its grant, then runs one short transfer
module lba_master_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // masters told to start, and the arbiter's grant
    input wire logic [4:0] want_i,
    input wire logic [4:0] grant_i,
    // local bus side
    output logic [4:0] request_o,
    output logic tip_n_o,
    output logic busy_n_o
);
    logic [4:0] req_q = 5'h00;
    logic [3:0] cnt_q = 4'h0;
    // request held until granted, dropped as the transfer ends
    always @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= 5'h00;
            cnt_q <= 4'h0;
        end else begin
            if (cnt_q == 4'h0 && |(grant_i & req_q)) cnt_q <= 4'h6;
            else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) req_q <= (req_q & ~grant_i) | want_i;
            else req_q <= req_q | want_i;
        end
    end
    // bus busy and cycle running only while a transfer counts down
    assign request_o = req_q;
    assign tip_n_o = (cnt_q == 4'h0);
    assign busy_n_o = (cnt_q == 4'h0);
endmodule // lba_master_model

// >>> sim/lba_arbiter_panel_asserts.sv
`timescale 1ns/1ps
`include "lba_defines.svh"
// watches grants, lamps and button outputs of the panel
module lba_arbiter_panel_asserts #(
    parameter int RESET_PULSE_CYC = `LBA_RESET_PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register writes
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    // arbitration and pins
    input wire logic [4:0] bus_request_i,
    input wire logic [4:0] bus_grant_o,
    input wire logic transfer_in_progress_n_i,
    input wire logic board_fail_i,
    // outputs
    input wire logic board_reset_o,
    input wire logic abort_irq_o,
    input wire logic [2:0] abort_irq_level_o,
    input wire logic fail_led_o,
    input wire logic run_led_o,
    input wire logic lan_led_o,
    input wire logic scsi_led_o
);
    logic [31:0] ctrl_q;
    logic [7:0] len_q;
    // shadow of the control word and length of the running reset pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 32'h0;
            len_q <= 8'h00;
        end else begin
            if (reg_write_i && reg_addr_i == 4'h0) ctrl_q <= reg_wdata_i;
            len_q <= board_reset_o ? len_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_new_grant;
        $rose(|bus_grant_o);
    endsequence
    a_grant_priority: assert property (s_new_grant |->
        bus_grant_o == ($past(bus_request_i) & (~$past(bus_request_i) + 5'h01))) else $error("wrong master granted");
    a_grant_onehot: assert property ($onehot0(bus_grant_o)) else $error("several grants");
    a_grant_held: assert property (|(bus_grant_o & bus_request_i) |=> $stable(bus_grant_o))
        else $error("grant moved while owner busy");
    a_lan_lamp: assert property (lan_led_o == $past(bus_grant_o[0])) else $error("lan lamp wrong");
    a_scsi_lamp: assert property (scsi_led_o == $past(bus_grant_o[2])) else $error("scsi lamp wrong");
    a_fail_lamp: assert property ($stable(board_fail_i)[*5] |-> fail_led_o == board_fail_i)
        else $error("fail lamp wrong");
    a_run_lamp: assert property ($stable(transfer_in_progress_n_i)[*5] |->
        run_led_o == !transfer_in_progress_n_i) else $error("run lamp wrong");
    a_reset_pulse_len: assert property ($fell(board_reset_o) |-> len_q == RESET_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_reset_gated: assert property ($rose(board_reset_o) |-> ctrl_q[0]) else $error("reset while disabled");
    a_abort_gated: assert property ($rose(abort_irq_o) |->
        ctrl_q[1] && abort_irq_level_o == ctrl_q[6:4]) else $error("abort irq wrong");
endmodule // lba_arbiter_panel_asserts

bind lba_arbiter_panel lba_arbiter_panel_asserts #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_chk (
    .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .bus_request_i, .bus_grant_o,
    .transfer_in_progress_n_i, .board_fail_i, .board_reset_o, .abort_irq_o, .abort_irq_level_o,
    .fail_led_o, .run_led_o, .lan_led_o, .scsi_led_o
);

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [4:0] want = 5'h00;
    logic [4:0] bus_request_i;
    logic [4:0] bus_grant_o;
    logic bus_busy_n_i;
    logic transfer_in_progress_n_i;
    logic board_fail_i = 1'b0;
    logic sys_controller_i = 1'b0;
    logic vme_strobe_driven_i = 1'b0;
    logic reset_button_i = 1'b0;
    logic abort_button_i = 1'b0;
    logic board_reset_o, sysreset_o, abort_irq_o;
    logic [2:0] abort_irq_level_o;
    logic fail_led_o, stat_led_o, run_led_o, sys_controller_led_o, lan_led_o, scsi_led_o, vme_led_o;
    logic [31:0] rd;
    logic [2:0] pv[4] = '{3'h7, 3'h2, 3'h5, 3'h0};
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_rst;
    int n_sys;
    // design with a short button filter
    lba_arbiter_panel #(.FILTER_CYC(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .bus_request_i(bus_request_i), .bus_busy_n_i(bus_busy_n_i), .bus_grant_o(bus_grant_o),
        .transfer_in_progress_n_i(transfer_in_progress_n_i), .board_fail_i(board_fail_i),
        .sys_controller_i(sys_controller_i), .vme_strobe_driven_i(vme_strobe_driven_i),
        .reset_button_i(reset_button_i), .abort_button_i(abort_button_i), .board_reset_o(board_reset_o),
        .sysreset_o(sysreset_o), .abort_irq_o(abort_irq_o), .abort_irq_level_o(abort_irq_level_o),
        .fail_led_o(fail_led_o), .stat_led_o(stat_led_o), .run_led_o(run_led_o),
        .sys_controller_led_o(sys_controller_led_o), .lan_led_o(lan_led_o), .scsi_led_o(scsi_led_o),
        .vme_led_o(vme_led_o)
    );
    lba_master_model i_masters (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .grant_i(bus_grant_o),
        .request_o(bus_request_i), .tip_n_o(transfer_in_progress_n_i), .busy_n_o(bus_busy_n_i));
    // clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // comparison helpers and register port cycles
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        @(negedge clk_i);
        rd = reg_rdata_o;
    endtask
    // hold a button 13 cycles and count pulse cycles over 40
    task automatic press(input bit ab);
        n_rst = 0;
        n_sys = 0;
        @(posedge clk_i);
        if (ab) abort_button_i <= 1'b1;
        else reset_button_i <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            if (i == 12) begin
                abort_button_i <= 1'b0;
                reset_button_i <= 1'b0;
            end
            #1;
            n_rst += int'(board_reset_o);
            n_sys += int'(sysreset_o);
        end
    endtask
    task automatic wg(input bit nz);
        for (int n = 0; n < 60 && ((bus_grant_o !== 5'h00) != nz); n++) cy(1);
    endtask
    // scenarios
    task automatic t_regs;
        rdr(4'h0);
        chk(rd, 32'h0);
        wr(4'h0, 32'hFFFF_FFFF);
        rdr(4'h0);
        chk(rd, 32'h77);
        cy(3);
        chk(stat_led_o, 1'b1);
        wr(4'h0, 32'h0);
        cy(3);
        chk(stat_led_o, 1'b0);
        rdr(4'hF);
        chk(rd, 32'h0);
    endtask
    task automatic t_bus;
        @(posedge clk_i);
        want <= 5'h1F;
        @(posedge clk_i);
        want <= 5'h00;
        for (int k = 0; k < 5; k++) begin
            wg(1'b1);
            chk(bus_grant_o, 32'h1 << k);
            cy(1);
            chk({lan_led_o, scsi_led_o}, {k == 0, k == 2});
            chk(vme_led_o, k == 3);
            rdr(4'h2);
            chk(rd, (32'(k) << 4) | (32'h1 << k));
            cy(4);
            chk(run_led_o, 1'b1);
            wg(1'b0);
        end
    endtask
    task automatic t_reset;
        wr(4'h0, 32'h0);
        sys_controller_i <= 1'b1;
        press(1'b0);
        chk(n_rst, 0);
        wr(4'h0, 32'h1);
        press(1'b0);
        chk(n_rst, 16);
        chk(n_sys, 16);
        wr(4'h0, 32'h1);
        sys_controller_i <= 1'b0;
        press(1'b0);
        chk(n_rst, 16);
        chk(n_sys, 0);
    endtask
    task automatic t_abort;
        wr(4'h0, 32'h0);
        press(1'b1);
        chk(abort_irq_o, 1'b0);
        wr(4'h0, 32'h52);
        press(1'b1);
        chk({abort_irq_o, abort_irq_level_o}, 4'hD);
        rdr(4'h1);
        chk(rd[7], 1'b1);
        cy(1);
        chk(abort_irq_o, 1'b0);
    endtask
    task automatic t_lamps;
        foreach (pv[i]) begin
            @(posedge clk_i);
            {board_fail_i, sys_controller_i, vme_strobe_driven_i} <= pv[i];
            cy(5);
            chk({fail_led_o, sys_controller_led_o, vme_led_o}, pv[i]);
        end
    endtask
    // verdict
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_bus();
        t_reset();
        t_abort();
        t_lamps();
        wrap_up();
    end
endmodule // tb
